// file: ucmc_pkg.sv
// shared constants, types and register map of the usb conditioner mode controller
package ucmc_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int I2C_RATE_KHZ    = 100;
    localparam int SAMPLE_DELAY_NS = 1000;
    localparam int SAMPLE_CYC      = (SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_PULSE_US    = 20;
    localparam int SUPPLY_STABLE_US = 100;

    // i2c target
    localparam logic [6:0] I2C_TARGET_ADDR = 7'h2C;

    // register offsets
    localparam logic [7:0] OFS_AC_BOOST = 8'h01;
    localparam logic [7:0] OFS_CFG_HOLD = 8'h03;
    localparam logic [7:0] OFS_STRAP_PIN_A = 8'h0E;

    // field positions
    localparam int ACB_LSB  = 4;
    localparam int ACB_MSB  = 6;
    localparam int HOLD_BIT = 0;
    localparam int DCB_LSB  = 0;
    localparam int DCB_MSB  = 2;

    // reset values
    localparam logic       HOLD_RESET = 1'b1;
    localparam logic [7:0] READ_ZERO  = 8'h00;

    // ac boost level codes
    localparam logic [2:0] ACB_LVL0 = 3'h0;
    localparam logic [2:0] ACB_LVL1 = 3'h1;
    localparam logic [2:0] ACB_LVL2 = 3'h3;
    localparam logic [2:0] ACB_LVL3 = 3'h7;

    // strap_pin_a level codes
    localparam logic [2:0] DCB_40MV = 3'h3;
    localparam logic [2:0] DCB_60MV = 3'h5;
    localparam logic [2:0] DCB_80MV = 3'h7;

    // tri-level dc strap as seen from the pin comparator
    typedef enum logic [1:0] {
        DCS_LOW  = 2'h0,
        DCS_MID  = 2'h1,
        DCS_HIGH = 2'h2
    } ucmc_dc_strap_t;

    // connection speed detector outputs
    typedef struct packed {
        logic ls;
        logic fs;
        logic hs;
    } ucmc_speed_t;

    // register write from the i2c target
    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } ucmc_wr_t;

    // compensation settings applied to the analog path
    typedef struct packed {
        logic       en;
        logic [2:0] ac_level;
        logic [2:0] dc_level;
    } ucmc_comp_t;

    function automatic logic [2:0] acb_code(input logic [1:0] lvl);
        logic [2:0] c;
        c = ACB_LVL0;
        unique case (lvl)
            2'h0: c = ACB_LVL0;
            2'h1: c = ACB_LVL1;
            2'h2: c = ACB_LVL2;
            2'h3: c = ACB_LVL3;
        endcase
        return c;
    endfunction

    function automatic logic [2:0] dcb_code(input logic [1:0] s);
        logic [2:0] c;
        c = DCB_60MV;
        unique case (s)
            DCS_LOW:  c = DCB_40MV;
            DCS_MID:  c = DCB_60MV;
            DCS_HIGH: c = DCB_80MV;
            default:  c = DCB_60MV;
        endcase
        return c;
    endfunction

endpackage

// file: ucmc_i2c_target.sv
// byte-wide i2c target with register pointer, open-drain data pin
`timescale 1ns/10ps
`default_nettype none
module ucmc_i2c_target
    import ucmc_pkg::*;
#(
    parameter logic [6:0] ADDR = I2C_TARGET_ADDR
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       enable,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    output ucmc_wr_t        wr,
    output logic [7:0]      rd_addr,
    input  wire logic [7:0] rd_data
);

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RECV = 5'h02,
        ST_ACK  = 5'h04,
        ST_SEND = 5'h08,
        ST_HACK = 5'h10
    } ucmc_i2c_st_t;

    typedef struct packed {
        ucmc_i2c_st_t st;
        logic         scl_q;
        logic         sda_q;
        logic [3:0]   cnt;
        logic [7:0]   sh;
        logic         rw;
        logic         addr_ph;
        logic         ptr_set;
        logic [7:0]   ptr;
        logic         drive;
        ucmc_wr_t     wr;
    } ucmc_i2c_state_t;

    localparam logic [3:0] BYTE_BITS = 4'h8;

    ucmc_i2c_state_t s_r;
    ucmc_i2c_state_t s_nxt;

    logic rise;
    logic fall;
    logic start;
    logic stop;

    assign rise  = scl_in & ~s_r.scl_q;
    assign fall  = ~scl_in & s_r.scl_q;
    assign start = s_r.scl_q & scl_in & s_r.sda_q & ~sda_in;
    assign stop  = s_r.scl_q & scl_in & ~s_r.sda_q & sda_in;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt       = s_r;
        s_nxt.scl_q = scl_in;
        s_nxt.sda_q = sda_in;
        s_nxt.wr.en = 1'b0;
        if (!enable) begin
            s_nxt.st    = ST_IDLE;
            s_nxt.drive = 1'b0;
        end else if (start) begin
            s_nxt.st      = ST_RECV;
            s_nxt.cnt     = 4'h0;
            s_nxt.addr_ph = 1'b1;
            s_nxt.drive   = 1'b0;
        end else if (stop) begin
            s_nxt.st    = ST_IDLE;
            s_nxt.drive = 1'b0;
        end else begin
            unique case (s_r.st)
                ST_IDLE: begin
                    s_nxt.drive = 1'b0;
                end
                ST_RECV: begin
                    if (rise) begin
                        s_nxt.sh  = {s_r.sh[6:0], sda_in};
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end else if (fall && s_r.cnt == BYTE_BITS) begin
                        s_nxt.addr_ph = 1'b0;
                        if (s_r.addr_ph) begin
                            // only our fixed address is acknowledged [R7]
                            if (s_r.sh[7:1] == ADDR) begin
                                s_nxt.rw      = s_r.sh[0];
                                s_nxt.ptr_set = ~s_r.sh[0];
                                s_nxt.drive   = 1'b1;
                                s_nxt.st      = ST_ACK;
                            end else begin
                                s_nxt.st = ST_IDLE;
                            end
                        end else begin
                            s_nxt.drive = 1'b1;
                            s_nxt.st    = ST_ACK;
                            if (s_r.ptr_set) begin
                                s_nxt.ptr     = s_r.sh;
                                s_nxt.ptr_set = 1'b0;
                            end else begin
                                s_nxt.wr.en   = 1'b1; // [R7]
                                s_nxt.wr.addr = s_r.ptr;
                                s_nxt.wr.data = s_r.sh;
                                s_nxt.ptr     = s_r.ptr + 8'h01;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (fall) begin
                        if (s_r.rw) begin
                            s_nxt.drive = ~rd_data[7]; // status readback [R8]
                            s_nxt.sh    = {rd_data[6:0], 1'b0};
                            s_nxt.cnt   = 4'h1;
                            s_nxt.st    = ST_SEND;
                        end else begin
                            s_nxt.drive = 1'b0;
                            s_nxt.cnt   = 4'h0;
                            s_nxt.st    = ST_RECV;
                        end
                    end
                end
                ST_SEND: begin
                    if (fall) begin
                        if (s_r.cnt == BYTE_BITS) begin
                            s_nxt.drive = 1'b0;
                            s_nxt.st    = ST_HACK;
                        end else begin
                            s_nxt.drive = ~s_r.sh[7];
                            s_nxt.sh    = {s_r.sh[6:0], 1'b0};
                            s_nxt.cnt   = s_r.cnt + 4'h1;
                        end
                    end
                end
                ST_HACK: begin
                    if (rise) begin
                        if (sda_in) begin
                            s_nxt.st = ST_IDLE;
                        end else begin
                            s_nxt.ptr = s_r.ptr + 8'h01;
                            s_nxt.st  = ST_ACK;
                        end
                    end
                end
                default: begin
                    s_nxt.st    = ST_IDLE;
                    s_nxt.drive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{st: ST_IDLE, scl_q: 1'b1, sda_q: 1'b1, cnt: 4'h0, sh: 8'h00,
                     rw: 1'b0, addr_ph: 1'b0, ptr_set: 1'b0, ptr: 8'h00, drive: 1'b0,
                     wr: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sda_out  = 1'b0;
    assign sda_oe_n = ~s_r.drive;
    assign wr       = s_r.wr;
    assign rd_addr  = s_r.ptr;

endmodule
`default_nettype wire

// file: ucmc_top.sv
// mode controller of a usb 2.0 high-speed signal conditioner
// Operation
// R1: reset low: shutdown, no compensation, channel passes
// R2: shutdown: connect-detect gives no indication
// R3: low speed: compensation off, connect-detect high
// R4: full speed: compensation off, connect-detect high
// R5: high speed: compensate with straps, connect-detect high
// R6: i2c enabled only if scl, sda high after reset
// R7: i2c answers fixed 7-bit address 0x2C
// R8: i2c runs at 100 kHz for config/status
// R9: host sets then clears hold after boost changes
// R10: hold 0 runs state machine, 1 halts it
// R11: hold resets set; auto-cleared unless i2c mode
// R12: ac boost field bits 6:4, loaded from strap
// R13: ac codes 000, 001, 011, 111
// R14: four ac levels from strap resistor
// R15: dc strap low/mid/high gives 40/60/80 mV
// R16: software keeps reserved fields at default
// R17: software uses read-modify-write
// R18: reset pulse held at least 20 us
// R19: reset held until supply stable 100 us
// R20: straps latched only at reset
// R21: strap_pin_a field 0x0E bits 2:0, codes 011/101/111
// R22: no connection, not shutdown: connect-detect low
`timescale 1ns/10ps
`default_nettype none
module ucmc_top
    import ucmc_pkg::*;
#(
    parameter int         SAMPLE_CYCLES = SAMPLE_CYC,
    parameter logic [6:0] TARGET_ADDR   = I2C_TARGET_ADDR
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [1:0] ac_boost_strap_pin,
    input  wire logic [1:0] strap_pin_a,
    input  wire ucmc_speed_t speed,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    output logic            connect_detect_out,
    output logic            channel_pass,
    output logic            i2c_mode,
    output ucmc_comp_t      comp
);

    // the 13-bit wait counter could serve 8192 cycles; SAMPLE_CYCLES is capped at 4096
    if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 4096) begin : g_bad_sample
        $error("SAMPLE_CYCLES out of range");
    end

    typedef enum logic [3:0] {
        ST_STRAP  = 4'h1,
        ST_SAMPLE = 4'h2,
        ST_HOLD   = 4'h4,
        ST_RUN    = 4'h8
    } ucmc_state_t;

    typedef struct packed {
        ucmc_state_t st;
        logic [12:0] wait_cnt;
        logic        i2c_mode;
        logic [2:0]  ac_boost_level_field;
        logic [2:0]  strap_pin_a_level_field;
        logic        hold;
        ucmc_comp_t  comp;
        logic        cd;
    } ucmc_top_state_t;

    localparam logic [12:0] SAMPLE_LAST = 13'(SAMPLE_CYCLES - 1);

    ucmc_top_state_t s_r;
    ucmc_top_state_t s_nxt;
    ucmc_wr_t        wr;
    logic [7:0]      rd_addr;
    logic [7:0]      rd_data;

    ////////////////////////////////////////////////////////////////////////////////
    // i2c target, only live once i2c mode was sampled

    ucmc_i2c_target #(
        .ADDR (TARGET_ADDR)
    ) u_i2c (
        .mclk     (mclk),
        .nrst     (nrst),
        .enable   (s_r.i2c_mode), // [R6]
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe_n (sda_oe_n),
        .wr       (wr),
        .rd_addr  (rd_addr),
        .rd_data  (rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register read mux, reserved bits read zero

    always_comb begin
        rd_data = READ_ZERO;
        unique case (rd_addr)
            OFS_AC_BOOST: rd_data[ACB_MSB:ACB_LSB] = s_r.ac_boost_level_field; // [R12]
            OFS_CFG_HOLD: rd_data[HOLD_BIT]        = s_r.hold;
            OFS_STRAP_PIN_A: rd_data[DCB_MSB:DCB_LSB] = s_r.strap_pin_a_level_field; // [R21]
            default:      rd_data = READ_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode sequencing

    always_comb begin
        s_nxt = s_r;
        // register writes land in any state after the straps are caught
        if (wr.en && s_r.st != ST_STRAP) begin
            unique case (wr.addr)
                OFS_AC_BOOST: s_nxt.ac_boost_level_field = wr.data[ACB_MSB:ACB_LSB];
                OFS_CFG_HOLD: s_nxt.hold = wr.data[HOLD_BIT]; // [R11]
                OFS_STRAP_PIN_A: s_nxt.strap_pin_a_level_field = wr.data[DCB_MSB:DCB_LSB];
                default: ;
            endcase
        end
        unique case (s_r.st)
            ST_STRAP: begin
                // straps are read once, right after reset release [R20]
                s_nxt.ac_boost_level_field = acb_code(ac_boost_strap_pin); // [R12] [R13] [R14]
                s_nxt.strap_pin_a_level_field = dcb_code(strap_pin_a); // [R15] [R21]
                s_nxt.wait_cnt             = 13'h0000;
                s_nxt.st                   = ST_SAMPLE;
            end
            ST_SAMPLE: begin
                if (s_r.wait_cnt == SAMPLE_LAST) begin
                    s_nxt.i2c_mode = scl_in & sda_in; // [R6]
                    if (!(scl_in & sda_in)) begin
                        s_nxt.hold = 1'b0; // [R11]
                    end
                    s_nxt.st = ST_HOLD;
                end else begin
                    s_nxt.wait_cnt = s_r.wait_cnt + 13'h0001;
                end
            end
            ST_HOLD: begin
                // halted for configuration: no compensation, no indication [R10]
                s_nxt.comp.en = 1'b0;
                s_nxt.cd      = 1'b0;
                if (!s_r.hold) begin
                    // restart picks up the current boost fields [R9]
                    s_nxt.comp.ac_level = s_r.ac_boost_level_field;
                    s_nxt.comp.dc_level = s_r.strap_pin_a_level_field;
                    s_nxt.st            = ST_RUN;
                end
            end
            ST_RUN: begin
                if (s_r.hold) begin
                    s_nxt.comp.en = 1'b0; // [R10]
                    s_nxt.cd      = 1'b0;
                    s_nxt.st      = ST_HOLD;
                end else begin
                    s_nxt.comp.en = speed.hs; // [R3] [R4] [R5]
                    s_nxt.cd      = speed.ls | speed.fs | speed.hs; // [R3] [R4] [R5] [R22]
                end
            end
            default: begin
                s_nxt.st = ST_HOLD;
            end
        endcase
    end

    // reset is the shutdown pin: compensation and connect-detect off while it is low, channel_pass stays high [R1] [R2]
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{st: ST_STRAP, wait_cnt: 13'h0000, i2c_mode: 1'b0,
                     ac_boost_level_field: ACB_LVL0, strap_pin_a_level_field: DCB_60MV,
                     hold: HOLD_RESET, comp: '0, cd: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign connect_detect_out = s_r.cd;
    assign comp               = s_r.comp;
    assign i2c_mode           = s_r.i2c_mode;
    assign channel_pass       = 1'b1; // [R1]

endmodule
`default_nettype wire

// file: ucmc_top_assertions.sv
// port-level checks of the conditioner mode controller
`timescale 1ns/10ps
`default_nettype none
module ucmc_top_checker
    import ucmc_pkg::*;
#(
    parameter int         SAMPLE_CYCLES = SAMPLE_CYC,
    parameter logic [6:0] TARGET_ADDR   = I2C_TARGET_ADDR
) (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [1:0]  ac_boost_strap_pin,
    input wire logic [1:0]  strap_pin_a,
    input wire ucmc_speed_t speed,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe_n,
    input wire logic        connect_detect_out,
    input wire logic        channel_pass,
    input wire logic        i2c_mode,
    input wire ucmc_comp_t  comp
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    sequence s_cd_up;
        $rose(connect_detect_out);
    endsequence
    sequence s_comp_on;
        comp.en ##1 comp.en;
    endsequence
    property p_wake_quiet;
        $rose(nrst) |-> !connect_detect_out && !comp.en;
    endproperty
    property p_channel;
        channel_pass;
    endproperty
    property p_hs_comp;
        comp.en |-> $past(speed.hs);
    endproperty
    property p_slow_no_comp;
        $past(speed.ls || speed.fs) && !$past(speed.hs) |-> !comp.en;
    endproperty
    property p_cd_cause;
        s_cd_up |-> $past(speed.ls || speed.fs || speed.hs);
    endproperty
    property p_idle_low;
        !$past(speed.ls || speed.fs || speed.hs) |-> !connect_detect_out;
    endproperty
    property p_mode_sticky;
        i2c_mode |=> i2c_mode;
    endproperty
    property p_mode_cause;
        $rose(i2c_mode) |-> $past(scl_in) && $past(sda_in);
    endproperty
    property p_quiet_bus;
        !i2c_mode |-> sda_oe_n;
    endproperty
    property p_levels_hold;
        s_comp_on |-> $stable(comp.ac_level) && $stable(comp.dc_level);
    endproperty
    ////////////////////////////////////////////////////////////////////////
    a_wake_quiet: assert property (p_wake_quiet)
        else $error("outputs active right after reset");
    a_channel: assert property (p_channel)
        else $error("usb channel not passing");
    a_hs_comp: assert property (p_hs_comp)
        else $error("compensation without high speed");
    a_slow_no_comp: assert property (p_slow_no_comp)
        else $error("compensation on low or full speed");
    a_cd_cause: assert property (p_cd_cause)
        else $error("connect detect rose without connection");
    a_idle_low: assert property (p_idle_low)
        else $error("connect detect high with no connection");
    a_mode_sticky: assert property (p_mode_sticky)
        else $error("i2c mode dropped");
    a_mode_cause: assert property (p_mode_cause)
        else $error("i2c mode without scl and sda high");
    a_quiet_bus: assert property (p_quiet_bus)
        else $error("sda driven outside i2c mode");
    a_levels_hold: assert property (p_levels_hold)
        else $error("boost levels moved while compensating");
endmodule
bind ucmc_top ucmc_top_checker #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .TARGET_ADDR  (TARGET_ADDR)
) i_ucmc_top_checker (
    .mclk              (mclk),
    .nrst              (nrst),
    .ac_boost_strap_pin(ac_boost_strap_pin),
    .strap_pin_a       (strap_pin_a),
    .speed             (speed),
    .scl_in            (scl_in),
    .sda_in            (sda_in),
    .sda_out           (sda_out),
    .sda_oe_n          (sda_oe_n),
    .connect_detect_out(connect_detect_out),
    .channel_pass      (channel_pass),
    .i2c_mode          (i2c_mode),
    .comp              (comp)
);
`default_nettype wire

// file: ucmc_i2c_host.sv
// i2c host model driving the conditioner register interface
`timescale 1ns/10ps
`default_nettype none
module ucmc_i2c_host
    import ucmc_pkg::*;
#(
    parameter int         HALF = 8,               // shortened bus period
    parameter logic [6:0] ADDR = I2C_TARGET_ADDR
) (
    input  wire logic mclk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_host
);
    task automatic wait_h;
        repeat (HALF) @(posedge mclk);
        #1;
    endtask
    task automatic idle(input logic lvl);
        scl = lvl;
        sda_host = lvl;
    endtask
    task automatic start;
        sda_host = 1'b1;
        wait_h();
        scl = 1'b1;
        wait_h();
        sda_host = 1'b0;
        wait_h();
        scl = 1'b0;
        wait_h();
    endtask
    task automatic stop;
        sda_host = 1'b0;
        wait_h();
        scl = 1'b1;
        wait_h();
        sda_host = 1'b1;
        wait_h();
    endtask
    // data changes only while scl is low
    task automatic bit_io(input logic b, output logic r);
        sda_host = b;
        wait_h();
        scl = 1'b1;
        wait_h();
        r = sda_wire;
        scl = 1'b0;
        wait_h();
    endtask
    task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                           output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(ack_in, r);
        ack = ~r;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic       k0;
        logic       k1;
        logic       k2;
        start();
        byte_io({a, 1'b0}, 1'b1, q, k0);
        byte_io(ofs, 1'b1, q, k1);
        byte_io(d, 1'b1, q, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask
    // pointer write, repeated start, one byte read ended by nack
    task automatic rd(input logic [7:0] ofs, output logic [7:0] q);
        logic k;
        start();
        byte_io({ADDR, 1'b0}, 1'b1, q, k);
        byte_io(ofs, 1'b1, q, k);
        start();
        byte_io({ADDR, 1'b1}, 1'b1, q, k);
        byte_io(8'hFF, 1'b1, q, k);
        stop();
    endtask
endmodule
`default_nettype wire

// file: ucmc_top_test.sv
// self-checking testbench of the conditioner mode controller
`timescale 1ns/10ps
`default_nettype none
module ucmc_top_test
    import ucmc_pkg::*;
;
    localparam int SMP = 4;
    logic        mclk;
    logic        nrst;
    logic [1:0]  acs;
    logic [1:0]  dcs;
    ucmc_speed_t speed;
    logic        scl;
    logic        sda_host;
    wire logic   sda_wire;
    logic        sda_out;
    logic        sda_oe_n;
    logic        cd;
    logic        chan;
    logic        i2c_mode;
    ucmc_comp_t  comp;
    int          errors;
    int          n_compared;
    logic [2:0]  ac_tab [4];
    logic [2:0]  dc_tab [4];
    // pulled-up wire: low when either party drives
    assign sda_wire = sda_host & (sda_oe_n | sda_out);
    ucmc_top #(.SAMPLE_CYCLES(SMP)) i_ucmc_top (
        .mclk(mclk), .nrst(nrst), .ac_boost_strap_pin(acs), .strap_pin_a(dcs),
        .speed(speed), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .connect_detect_out(cd), .channel_pass(chan),
        .i2c_mode(i2c_mode), .comp(comp));
    ucmc_i2c_host i_ucmc_i2c_host (
        .mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_host(sda_host));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task close_out;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task do_reset(input logic [1:0] a, input logic [1:0] d, input logic i2c);
        nrst = 1'b0;
        acs = a;
        dcs = d;
        speed = 3'h0;
        i_ucmc_i2c_host.idle(i2c);
        cyc(4);
        check("reset outputs", {6'h00, cd, comp.en}, 8'h00);
        check("channel pass", {7'h00, chan}, 8'h01);
        nrst = 1'b1;
        cyc(SMP + 6);
    endtask
    task spd(input logic [2:0] s, input logic cd_e, input logic en_e);
        speed = s;
        cyc(2);
        check("connect detect", {7'h00, cd}, {7'h00, cd_e});
        check("comp enable", {7'h00, comp.en}, {7'h00, en_e});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_strap_table;
        for (int a = 0; a < 4; a++) begin
            for (int d = 0; d < 4; d++) begin
                do_reset(2'(a), 2'(d), 1'b0);
                check("mode", {7'h00, i2c_mode}, 8'h00);
                spd(3'h1, 1'b1, 1'b1);
                check("ac level", {5'h00, comp.ac_level}, {5'h00, ac_tab[a]});
                check("dc level", {5'h00, comp.dc_level}, {5'h00, dc_tab[d]});
            end
        end
        $display("test strap_table done");
    endtask
    task t_speed_modes;
        logic ok;
        do_reset(2'h2, 2'h1, 1'b0);
        spd(3'h0, 1'b0, 1'b0);
        spd(3'h4, 1'b1, 1'b0);
        spd(3'h2, 1'b1, 1'b0);
        spd(3'h1, 1'b1, 1'b1);
        acs = 2'h0;
        dcs = 2'h2;
        i_ucmc_i2c_host.wr(I2C_TARGET_ADDR, OFS_CFG_HOLD, 8'h01, ok);
        check("ack outside mode", {7'h00, ok}, 8'h00);
        spd(3'h0, 1'b0, 1'b0);
        spd(3'h1, 1'b1, 1'b1);
        check("ac kept", {5'h00, comp.ac_level}, {5'h00, ACB_LVL2});
        check("dc kept", {5'h00, comp.dc_level}, {5'h00, DCB_60MV});
        $display("test speed_modes done");
    endtask
    task t_i2c;
        logic       ok;
        logic [7:0] q;
        do_reset(2'h1, 2'h0, 1'b1);
        check("mode", {7'h00, i2c_mode}, 8'h01);
        spd(3'h1, 1'b0, 1'b0);
        i_ucmc_i2c_host.rd(OFS_AC_BOOST, q);
        check("ac reg", q, 8'h10);
        i_ucmc_i2c_host.rd(OFS_CFG_HOLD, q);
        check("hold reg", q, 8'h01);
        i_ucmc_i2c_host.rd(OFS_STRAP_PIN_A, q);
        check("dc reg", q, 8'h03);
        i_ucmc_i2c_host.rd(8'h05, q);
        check("unmapped", q, 8'h00);
        i_ucmc_i2c_host.wr(7'h2D, OFS_AC_BOOST, 8'h30, ok);
        check("foreign ack", {7'h00, ok}, 8'h00);
        i_ucmc_i2c_host.rd(OFS_AC_BOOST, q);
        check("ac untouched", q, 8'h10);
        i_ucmc_i2c_host.wr(I2C_TARGET_ADDR, OFS_AC_BOOST, (q & 8'h8F) | 8'h70, ok);
        check("ack", {7'h00, ok}, 8'h01);
        i_ucmc_i2c_host.wr(I2C_TARGET_ADDR, OFS_STRAP_PIN_A, 8'h07, ok);
        i_ucmc_i2c_host.wr(I2C_TARGET_ADDR, OFS_CFG_HOLD, 8'h01, ok);
        i_ucmc_i2c_host.wr(I2C_TARGET_ADDR, OFS_CFG_HOLD, 8'h00, ok);
        spd(3'h1, 1'b1, 1'b1);
        check("ac applied", {5'h00, comp.ac_level}, {5'h00, ACB_LVL3});
        check("dc applied", {5'h00, comp.dc_level}, {5'h00, DCB_80MV});
        i_ucmc_i2c_host.wr(I2C_TARGET_ADDR, OFS_CFG_HOLD, 8'h01, ok);
        spd(3'h1, 1'b0, 1'b0);
        i_ucmc_i2c_host.rd(OFS_AC_BOOST, q);
        check("ac readback", q, 8'h70);
        i_ucmc_i2c_host.rd(OFS_STRAP_PIN_A, q);
        check("dc readback", q, 8'h07);
        $display("test i2c done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        n_compared = 0;
        ac_tab = '{ACB_LVL0, ACB_LVL1, ACB_LVL2, ACB_LVL3};
        // code 3 on the dc strap reads as mid
        dc_tab = '{DCB_40MV, DCB_60MV, DCB_80MV, DCB_60MV};
        t_strap_table();
        t_speed_modes();
        t_i2c();
        close_out();
    end
    initial begin
        repeat (40000) @(posedge mclk);
        $display("watchdog expired");
        errors++;
        close_out();
    end
endmodule
`default_nettype wire
